// ### shared/ldtr_regs.svh
`ifndef LDTR_REGS_SVH
`define LDTR_REGS_SVH
`define LDTR_OFF_THRESH 8'h09
`define LDTR_OFF_RES12 8'h0a
`define LDTR_OFF_RES34 8'h0b
`define LDTR_OFF_LINEOUT 8'h0c
`define LDTR_OFF_STATE12 8'h0d
`define LDTR_OFF_LOEN 8'h10
`define LDTR_RST_THRESH 8'h11
`define LDTR_RST_RES 8'h00
`define LDTR_RST_STATE12 8'h24
`define LDTR_RST_LOEN 8'h00
`define LDTR_HI_NIB 7:4
`define LDTR_LO_NIB 3:0
`define LDTR_LO_RSVD 4'h0
`endif

// ### shared/ldtr_pkg.sv
package ldtr_pkg;
    typedef enum logic [2:0] {
        ST_PLAY = 3'h0,
        ST_FLOATING = 3'h1,
        ST_MUTE = 3'h2,
        ST_LOAD_CHECK = 3'h3,
        ST_SHUTDOWN_AR = 3'h4,
        ST_SHUTDOWN = 3'h5
    } ldtr_chan_state_t;
    typedef struct packed {
        logic ground_short_flag;
        logic supply_short_flag;
        logic open_load_flag;
        logic shorted_load_flag;
    } ldtr_flags_t;
    typedef struct packed {
        logic start;
        logic done;
        ldtr_flags_t flags;
        logic line_output_flag;
    } ldtr_load_check_state_evt_t;
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } ldtr_ahb_req_t;
endpackage

// ### rtl/ldtr_chan_result.sv
`timescale 1ns/1ps
`default_nettype none
module ldtr_chan_result
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ldtr_pkg::ldtr_load_check_state_evt_t evt,
    input wire logic lineout_enable,
    output ldtr_pkg::ldtr_flags_t flags_q,
    output logic line_output_q,
    output logic pass_q
);
    import ldtr_pkg::*;
    // Clear on start; a report in the same cycle as a start still lands.
    wire ldtr_flags_t flags_d = evt.done ? evt.flags
        : (evt.start ? ldtr_flags_t'(4'h0) : flags_q);
    wire line_d = evt.done ? (evt.line_output_flag & lineout_enable)
        : (evt.start ? 1'b0 : line_output_q);
    wire pass_d = evt.done ? (evt.flags == 4'h0) : (evt.start ? 1'b0 : pass_q);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_q <= '0;
            line_output_q <= 1'b0;
            pass_q <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            line_output_q <= line_d;
            pass_q <= pass_d;
        end
    end
    a_lineout_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !lineout_enable && evt.done |=> !line_output_q)
        else $error("line output flag set while check disabled");
    a_start_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        evt.start && !evt.done |=> flags_q == 4'h0 && !pass_q)
        else $error("start did not clear results");
    a_pass_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pass_q |-> flags_q == 4'h0)
        else $error("pass bit with a fault flag");
endmodule
`default_nettype wire

// ### rtl/ldtr_regs_top.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ldtr_regs.svh"
module ldtr_regs_top
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire ldtr_pkg::ldtr_load_check_state_evt_t [3:0] load_check_state_evt,
    input wire ldtr_pkg::ldtr_chan_state_t ch1_state_field,
    input wire ldtr_pkg::ldtr_chan_state_t ch2_state_field,
    output logic [3:0] ch3_short_threshold,
    output logic [3:0] ch4_short_threshold
);
    import ldtr_pkg::*;

    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:2] == {22'h0, off});
    endfunction

    ldtr_flags_t [3:0] flags;
    logic [3:0] line_out;
    logic [3:0] pass;
    logic [7:0] thresh_q;
    logic [3:0] loen_q;
    logic [2:0] st1_q;
    logic [2:0] st2_q;
    logic wr_pend_q;
    logic [31:0] wr_addr_q;

    // The line-out enables sit at bits 3..0 as channels 1..4.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_chan
            ldtr_chan_result u_res (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .evt(load_check_state_evt[g]),
                .lineout_enable(loen_q[3 - g]),
                .flags_q(flags[g]),
                .line_output_q(line_out[g]),
                .pass_q(pass[g])
            );
        end
    endgenerate

    wire addr_ok = hsel && hready && htrans[1];
    wire wr_take = addr_ok && hwrite;
    wire rd_take = addr_ok && !hwrite;
    wire wr_thresh = wr_pend_q && hit(wr_addr_q, `LDTR_OFF_THRESH);
    wire wr_loen = wr_pend_q && hit(wr_addr_q, `LDTR_OFF_LOEN);
    wire [7:0] res12 = {flags[0], flags[1]};
    wire [7:0] res34 = {flags[2], flags[3]};
    wire [7:0] lo_reg = {`LDTR_LO_RSVD, line_out[0], line_out[1], line_out[2], line_out[3]};
    wire [7:0] st12 = {st1_q, st2_q, pass[0], pass[1]};
    // Read-only offsets have no write path, so their contents never move on a write.
    wire [7:0] rd_mux = hit(haddr, `LDTR_OFF_THRESH) ? thresh_q
        : hit(haddr, `LDTR_OFF_RES12) ? res12
        : hit(haddr, `LDTR_OFF_RES34) ? res34
        : hit(haddr, `LDTR_OFF_LINEOUT) ? lo_reg
        : hit(haddr, `LDTR_OFF_STATE12) ? st12
        : hit(haddr, `LDTR_OFF_LOEN) ? {4'h0, loen_q}
        : 8'h00;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ch3_short_threshold = thresh_q[`LDTR_HI_NIB];
    assign ch4_short_threshold = thresh_q[`LDTR_LO_NIB];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0;
            hrdata <= 32'h0;
        end
        else
        begin
            wr_pend_q <= wr_take;
            if (wr_take)
                wr_addr_q <= haddr;
            if (rd_take)
                hrdata <= {24'h0, rd_mux};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thresh_q <= `LDTR_RST_THRESH;
            loen_q <= 4'h0;
        end
        else
        begin
            if (wr_thresh)
                thresh_q <= hwdata[7:0];
            if (wr_loen)
                loen_q <= hwdata[3:0];
        end
    end

    // State fields are sampled so that a read sees a stable snapshot.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st1_q <= 3'h1;
            st2_q <= 3'h1;
        end
        else
        begin
            st1_q <= ch1_state_field;
            st2_q <= ch2_state_field;
        end
    end

    a_thresh_reset: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> thresh_q == 8'h11)
        else $error("threshold reset value wrong");
    a_thresh_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_thresh |=> thresh_q == $past(hwdata[7:0]))
        else $error("threshold write lost");
    a_ch4_nibble: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ch4_short_threshold == thresh_q[3:0])
        else $error("channel 4 threshold misplaced");
    a_ro_unchanged: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_pend_q && hit(wr_addr_q, 8'h0a) && load_check_state_evt[0] == '0 && load_check_state_evt[1] == '0
        |=> res12 == $past(res12))
        else $error("write altered result register");
    a_lo_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take && hit(haddr, 8'h0c) |=> hrdata[31:4] == 28'h0)
        else $error("reserved line-out bits nonzero");
    a_state_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take && hit(haddr, 8'h0d) |=> hrdata[7:5] == $past(st1_q))
        else $error("state field read wrong");
    a_res_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take && hit(haddr, 8'h0b) |=> hrdata[7] == $past(flags[2].ground_short_flag))
        else $error("channel 3 ground flag misplaced");
    a_ch1_shorted: assert property (@(posedge ref_clk) disable iff (!rst_n)
        load_check_state_evt[0].done |=> res12[4] == $past(load_check_state_evt[0].flags.shorted_load_flag))
        else $error("channel 1 shorted flag not recorded");
    a_lo_ch4_place: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take && hit(haddr, 8'h0c) |=> hrdata[0] == $past(line_out[3]))
        else $error("channel 4 line output flag misplaced");
    a_pass_place: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take && hit(haddr, 8'h0d) |=> hrdata[1:0] == $past({pass[0], pass[1]}))
        else $error("pass bits misplaced");
    a_ch4_ground: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take && hit(haddr, 8'h0b) |=> hrdata[3] == $past(flags[3].ground_short_flag))
        else $error("channel 4 ground flag misplaced");
    a_thresh_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wr_thresh |=> thresh_q == $past(thresh_q))
        else $error("threshold changed without a write");
endmodule
`default_nettype wire

// ### test/tb_ldtr_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ldtr_regs_top;
    import ldtr_pkg::*;
    logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    ldtr_load_check_state_evt_t [3:0] load_check_state_evt;
    ldtr_chan_state_t ch1_state_field, ch2_state_field;
    logic [3:0] ch3_short_threshold, ch4_short_threshold, f;
    int n_fail = 0, n_tests = 0, cyc = 0, c;
    logic [3:0] m_fl [4];
    logic m_lo [4], m_pass [4];
    logic [7:0] m_thr;
    logic [3:0] m_en;
    logic [31:0] addrs [8] = '{32'h24, 32'h28, 32'h2c, 32'h30, 32'h34, 32'h40, 32'h38, 32'h0};
    assign hready = hreadyout;
    ldtr_regs_top ldtr_regs_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .load_check_state_evt(load_check_state_evt), .ch1_state_field(ch1_state_field),
        .ch2_state_field(ch2_state_field), .ch3_short_threshold(ch3_short_threshold),
        .ch4_short_threshold(ch4_short_threshold));
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // The ceiling leaves over twenty times the expected run length.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("tests %0d errors %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [31:0] mreg(input logic [31:0] a);
        case (a)
            32'h24: mreg = {24'h0, m_thr};
            32'h28: mreg = {24'h0, m_fl[0], m_fl[1]};
            32'h2c: mreg = {24'h0, m_fl[2], m_fl[3]};
            32'h30: mreg = {28'h0, m_lo[0], m_lo[1], m_lo[2], m_lo[3]};
            32'h34: mreg = {24'h0, ch1_state_field, ch2_state_field, m_pass[0], m_pass[1]};
            32'h40: mreg = {28'h0, m_en};
            default: mreg = 32'h0;
        endcase
    endfunction
    task automatic check_all();
        foreach (addrs[i])
        begin
            ahb(1'b0, addrs[i], 32'h0);
            check("register", rd, mreg(addrs[i]));
        end
        check("ch3 threshold", ch3_short_threshold, m_thr[7:4]);
        check("ch4 threshold", ch4_short_threshold, m_thr[3:0]);
    endtask
    task automatic evt(input int ch, input logic [6:0] v);
        @(posedge ref_clk);
        load_check_state_evt[ch] <= v;
        @(posedge ref_clk);
        load_check_state_evt <= '0;
    endtask
    initial
    begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, load_check_state_evt} = '0;
        hsize = 3'h2;
        ch1_state_field = ST_FLOATING;
        ch2_state_field = ST_FLOATING;
        m_thr = 8'h11;
        m_en = 4'h0;
        for (int i = 0; i < 4; i++)
            {m_fl[i], m_lo[i], m_pass[i]} = '0;
        void'($urandom(32'h3fac));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_all();
        // Writes to the result and state places must leave them alone.
        foreach (addrs[i])
        begin
            if (i != 0 && i != 5)
            begin
                ahb(1'b1, addrs[i], ~mreg(addrs[i]));
                check("response", {hreadyout, hresp}, 32'h2);
            end
        end
        m_thr = $urandom;
        m_en = $urandom;
        ahb(1'b1, 32'h24, {24'h0, m_thr});
        ahb(1'b1, 32'h40, {28'h0, m_en});
        check_all();
        for (int k = 0; k < 24; k++)
        begin
            c = $urandom % 4;
            f = (k % 3 == 0) ? 4'h0 : 4'($urandom);
            evt(c, 7'h40);
            {m_fl[c], m_lo[c], m_pass[c]} = '0;
            if (k % 4 == 0)
                check_all();
            evt(c, {2'b01, f, 1'b1});
            m_fl[c] = f;
            m_lo[c] = m_en[3 - c];
            m_pass[c] = (f == 4'h0);
            ch1_state_field <= ldtr_chan_state_t'(3'(k % 6));
            ch2_state_field <= ldtr_chan_state_t'(3'(5 - k % 6));
            check_all();
            if (k == 12)
            begin
                m_en = $urandom;
                ahb(1'b1, 32'h40, {28'h0, m_en});
            end
        end
        give_verdict();
    end
endmodule
`default_nettype wire
